/* File: shared/counter_array_pkg.sv */
package counter_array_pkg;
  // Array size and the one module that may act as a guard timer
  localparam int NUM_MODULES = 5;
  localparam int GUARD_MODULE = 4;

  // Register offsets on the register port
  localparam logic [7:0] ARRAY_CONTROL_ADDR = 8'hd8;
  localparam logic [7:0] ARRAY_MODE_ADDR = 8'hd9;
  localparam logic [7:0] MODE_BASE = 8'hda;
  localparam logic [7:0] COUNTER_LOW_ADDR = 8'he9;
  localparam logic [7:0] COMPARE_LOW_BASE = 8'hea;
  localparam logic [7:0] COUNTER_HIGH_ADDR = 8'hf9;
  localparam logic [7:0] COMPARE_HIGH_BASE = 8'hfa;

  // Field positions of module_mode_reg
  localparam int COMPARATOR_EN_BIT = 6;
  localparam int RISE_CAPTURE_BIT = 5;
  localparam int FALL_CAPTURE_BIT = 4;
  localparam int MATCH_EN_BIT = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int PWM_EN_BIT = 1;
  localparam int IRQ_EN_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h7f;

  // Field positions of array_control_reg and array mode register
  localparam int RUN_BIT = 6;
  localparam int GUARD_TIMER_BIT = 6;

  // Values after reset
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic PIN_IDLE = 1'b1;

  // Low byte value at which the next count wraps to zero
  localparam logic [7:0] LOW_BYTE_TOP = 8'hff;
endpackage

/* File: rtl/pin_edge_detect.sv */
module pin_edge_detect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  import counter_array_pkg::*;

  logic sync_first, sync_second, prev;
  logic next_first, next_second, next_prev;

  // Two-stage synchroniser plus one history stage
  always_comb begin
    next_first = pin_in;
    next_second = sync_first;
    next_prev = sync_second;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_first <= PIN_IDLE;
      sync_second <= PIN_IDLE;
      prev <= PIN_IDLE;
    end else begin
      sync_first <= next_first;
      sync_second <= next_second;
      prev <= next_prev;
    end
  end

  // One pulse per transition
  assign rise = sync_second & ~prev;
  assign fall = ~sync_second & prev;
endmodule // pin_edge_detect

/* File: rtl/channel_output.sv */
module channel_output (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic toggle_mode,
  input wire logic pwm_mode,
  input wire logic match_hit,
  input wire logic [7:0] count_low,
  input wire logic [7:0] duty,
  output logic pin_out,
  output logic pin_oe_n
);
  import counter_array_pkg::*;

  logic next_pin_out, next_oe_n;

  // Pin level: duty compare in pwm, inversion on match in toggle mode
  always_comb begin
    next_pin_out = pin_out;
    if (pwm_mode) begin
      next_pin_out = (count_low >= duty);
    end else if (toggle_mode && match_hit) begin
      next_pin_out = ~pin_out;
    end
    next_oe_n = ~(pwm_mode | toggle_mode);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= PIN_IDLE;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_oe_n;
    end
  end
endmodule // channel_output

/* File: rtl/counter_array.sv */
// Overview of operation
// - Capture on rising, falling, or either edge per the two capture bits.
// - A valid pin edge copies the 16-bit counter into the compare bytes.
// - Capture or match sets the event flag; request needs flag and enable.
// - With comparator and match enabled, compare counter each count.
// - Writing a compare high byte sets that module's comparator enable.
// - Writing a compare low byte clears a set comparator enable.
// - Toggle, match and comparator enabled, pwm off: invert pin on every match.
// - All pwm outputs share the counter period; duty per module.
// - Pwm pin low while counter low byte is below active duty, else high.
// - On low byte wrap, active duty reloads from the high compare byte.
// - Pwm mode needs both pwm enable and comparator enable set.
// - Only module 4 can be the guard timer; otherwise it works normally.
// - Guard match raises an internal reset, never the external reset pin.
// - Clearing the guard enable before a match prevents the reset.
// - Mode register bits 6..0 as listed; bit 7 reserved; reset zero.
// - Five identical modules, each with its own compare bytes.
//
// Chosen here: the strobed register port.
module counter_array (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [counter_array_pkg::NUM_MODULES-1:0] pin_in,
  output logic [counter_array_pkg::NUM_MODULES-1:0] pin_out,
  output logic [counter_array_pkg::NUM_MODULES-1:0] pin_oe_n,
  output logic irq_request,
  output logic internal_reset
);
  import counter_array_pkg::*;

  localparam int N = NUM_MODULES;

  // Address inside a block of per-module registers
  function automatic logic in_block(input logic [7:0] a,
                                    input logic [7:0] base);
    return (a >= base) && (a < base + 8'(N));
  endfunction

  // Module index of an address inside a block
  function automatic logic [2:0] block_index(input logic [7:0] a,
                                             input logic [7:0] base);
    logic [7:0] diff;
    diff = a - base;
    return diff[2:0];
  endfunction

  logic [15:0] count, next_count;
  logic run, next_run;
  logic guard_en, next_guard_en;
  logic [N-1:0] flag, next_flag;
  logic [7:0] mode [N];
  logic [7:0] next_mode [N];
  logic [7:0] low [N];
  logic [7:0] next_low [N];
  logic [7:0] high [N];
  logic [7:0] next_high [N];
  logic [7:0] next_rdata;
  logic next_irq, next_internal_reset;

  logic tick, wrap;
  logic [N-1:0] rise, fall, cap_evt, hit, irq_en;
  logic [N-1:0] pwm_active, toggle_mode;

  // Pin edge detectors and output stages, one per module
  for (genvar g = 0; g < N; g++) begin : g_module
    pin_edge_detect u_edge (
      .clk(clk),
      .reset_n(reset_n),
      .pin_in(pin_in[g]),
      .rise(rise[g]),
      .fall(fall[g])
    );
    channel_output u_out (
      .clk(clk),
      .reset_n(reset_n),
      .toggle_mode(toggle_mode[g]),
      .pwm_mode(pwm_active[g]),
      .match_hit(hit[g]),
      .count_low(count[7:0]),
      .duty(low[g]),
      .pin_out(pin_out[g]),
      .pin_oe_n(pin_oe_n[g])
    );
  end

  // Counter advance and per-module event decode
  always_comb begin
    tick = run;
    wrap = tick && (count[7:0] == LOW_BYTE_TOP);
    for (int i = 0; i < N; i++) begin
      cap_evt[i] = (mode[i][RISE_CAPTURE_BIT] & rise[i]) |
                   (mode[i][FALL_CAPTURE_BIT] & fall[i]);
      hit[i] = tick && mode[i][COMPARATOR_EN_BIT] &&
               mode[i][MATCH_EN_BIT] &&
               (count == {high[i], low[i]});
      irq_en[i] = mode[i][IRQ_EN_BIT];
      pwm_active[i] = mode[i][PWM_EN_BIT] &&
                      mode[i][COMPARATOR_EN_BIT];
      toggle_mode[i] = mode[i][TOGGLE_BIT] && mode[i][MATCH_EN_BIT] &&
                       mode[i][COMPARATOR_EN_BIT] && !pwm_active[i];
    end
  end

  // Counter, control bits and event flags
  always_comb begin
    next_count = count;
    if (tick) begin
      next_count = count + 16'h0001;
    end
    if (wr && addr == COUNTER_LOW_ADDR) begin
      next_count[7:0] = wdata;
    end
    if (wr && addr == COUNTER_HIGH_ADDR) begin
      next_count[15:8] = wdata;
    end
    next_run = run;
    next_flag = flag;
    if (wr && addr == ARRAY_CONTROL_ADDR) begin
      next_run = wdata[RUN_BIT];
      next_flag = wdata[N-1:0];
    end
    next_flag = next_flag | hit | cap_evt;
    next_guard_en = guard_en;
    if (wr && addr == ARRAY_MODE_ADDR) begin
      next_guard_en = wdata[GUARD_TIMER_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= COUNTER_RESET;
      run <= 1'b0;
      flag <= '0;
      guard_en <= 1'b0;
    end else begin
      count <= next_count;
      run <= next_run;
      flag <= next_flag;
      guard_en <= next_guard_en;
    end
  end

  // Mode and compare bytes per module
  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_mode[i] = mode[i];
      next_low[i] = low[i];
      next_high[i] = high[i];
      if (wr && in_block(addr, MODE_BASE) &&
          block_index(addr, MODE_BASE) == 3'(i)) begin
        next_mode[i] = wdata & MODE_WRITE_MASK;
      end
      if (wr && in_block(addr, COMPARE_LOW_BASE) &&
          block_index(addr, COMPARE_LOW_BASE) == 3'(i)) begin
        next_low[i] = wdata;
        next_mode[i][COMPARATOR_EN_BIT] = 1'b0;
      end
      if (wr && in_block(addr, COMPARE_HIGH_BASE) &&
          block_index(addr, COMPARE_HIGH_BASE) == 3'(i)) begin
        next_high[i] = wdata;
        next_mode[i][COMPARATOR_EN_BIT] = 1'b1;
      end
      if (pwm_active[i] && wrap) begin
        next_low[i] = high[i];
      end
      if (cap_evt[i]) begin
        next_low[i] = count[7:0];
        next_high[i] = count[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        mode[i] <= MODE_RESET;
        low[i] <= COMPARE_RESET;
        high[i] <= COMPARE_RESET;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        mode[i] <= next_mode[i];
        low[i] <= next_low[i];
        high[i] <= next_high[i];
      end
    end
  end

  // Read data, interrupt request and guard reset
  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      if (addr == COUNTER_LOW_ADDR) begin
        next_rdata = count[7:0];
      end else if (addr == COUNTER_HIGH_ADDR) begin
        next_rdata = count[15:8];
      end else if (addr == ARRAY_CONTROL_ADDR) begin
        next_rdata = 8'h00;
        next_rdata[RUN_BIT] = run;
        next_rdata[N-1:0] = flag;
      end else if (addr == ARRAY_MODE_ADDR) begin
        next_rdata = 8'h00;
        next_rdata[GUARD_TIMER_BIT] = guard_en;
      end else if (in_block(addr, MODE_BASE)) begin
        next_rdata = mode[block_index(addr, MODE_BASE)];
      end else if (in_block(addr, COMPARE_LOW_BASE)) begin
        next_rdata = low[block_index(addr, COMPARE_LOW_BASE)];
      end else if (in_block(addr, COMPARE_HIGH_BASE)) begin
        next_rdata = high[block_index(addr, COMPARE_HIGH_BASE)];
      end
    end
    next_irq = |(flag & irq_en);
    next_internal_reset = guard_en && hit[GUARD_MODULE];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
      irq_request <= 1'b0;
      internal_reset <= 1'b0;
    end else begin
      rdata <= next_rdata;
      irq_request <= next_irq;
      internal_reset <= next_internal_reset;
    end
  end

  // Checks on the modules that the scenarios exercise
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_high_write_arms: assert property (
    wr && addr == COMPARE_HIGH_BASE |=> mode[0][COMPARATOR_EN_BIT]
  ) else $error("compare high write did not arm comparator");

  a_low_write_disarm: assert property (
    wr && addr == COMPARE_LOW_BASE |=> !mode[0][COMPARATOR_EN_BIT]
  ) else $error("compare low write did not disarm comparator");

  a_capture_loads: assert property (
    cap_evt[1] |=> {high[1], low[1]} == $past(count)
  ) else $error("capture did not load counter value");

  a_event_sets_flag: assert property (
    (hit | cap_evt) != '0 |=>
      (flag & $past(hit | cap_evt)) == $past(hit | cap_evt)
  ) else $error("event flag not set");

  a_irq_gated: assert property (
    (flag & irq_en) == '0 |=> !irq_request
  ) else $error("interrupt request without enabled flag");

  a_irq_raised: assert property (
    (flag & irq_en) != '0 |=> irq_request
  ) else $error("enabled flag did not raise interrupt request");

  a_counter_carry: assert property (
    tick && count == 16'h00ff && !wr |=> count == 16'h0100
  ) else $error("counter carry into high byte failed");

  a_counter_holds: assert property (
    !tick && !wr |=> count == $past(count)
  ) else $error("counter moved while stopped");

  a_match_toggle_pin: assert property (
    hit[2] && toggle_mode[2] |=> pin_out[2] != $past(pin_out[2])
  ) else $error("pin did not toggle on match");

  a_pwm_pin_level: assert property (
    pwm_active[3] |=>
      pin_out[3] == ($past(count[7:0]) >= $past(low[3]))
  ) else $error("pwm pin level wrong");

  a_pwm_drives_pin: assert property (
    pwm_active[3] |=> !pin_oe_n[3]
  ) else $error("pwm output not driven");

  a_pwm_duty_reload: assert property (
    pwm_active[3] && wrap && !cap_evt[3] |=> low[3] == $past(high[3])
  ) else $error("duty byte not reloaded at wrap");

  a_guard_reset_fires: assert property (
    guard_en && hit[GUARD_MODULE] |=> internal_reset ##1 !internal_reset
  ) else $error("guard match did not pulse internal reset");

  a_guard_off_quiet: assert property (
    !guard_en |=> !internal_reset
  ) else $error("internal reset while guard disabled");

  a_single_edge_event: assert property (
    rise[1] |=> !rise[1]
  ) else $error("two capture events for one transition");

  c_capture_seen: cover property (cap_evt[1]);
  c_match_seen: cover property (hit[2] && toggle_mode[2]);
  c_pwm_wrap: cover property (pwm_active[3] && wrap);
  c_guard_reset: cover property (internal_reset);
endmodule // counter_array

/* File: bench/pin_partner.sv */
module pin_partner (
  input wire logic [counter_array_pkg::NUM_MODULES-1:0] pin_out,
  input wire logic [counter_array_pkg::NUM_MODULES-1:0] pin_oe_n,
  input wire logic [counter_array_pkg::NUM_MODULES-1:0] drive,
  output logic [counter_array_pkg::NUM_MODULES-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import counter_array_pkg::*;
  // Pin level: device output when enabled, else far side level
  always_comb begin
    for (int i = 0; i < NUM_MODULES; i++) begin
      pin_in[i] = pin_oe_n[i] ? drive[i] : pin_out[i];
    end
  end
endmodule // pin_partner

/* File: bench/counter_array_tb_top.sv */
module counter_array_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import counter_array_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] pin_oe_n;
  logic [4:0] drive = 5'h1f;
  logic irq_request;
  logic internal_reset;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n_rst = 0;
  logic [7:0] d;

  always #5 clk = ~clk;

  counter_array u_counter_array (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .irq_request(irq_request), .internal_reset(internal_reset));

  pin_partner u_pin_partner (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .drive(drive), .pin_in(pin_in));

  // Cycle ceiling and internal reset pulse count
  always @(posedge clk) begin
    cycles++;
    if (internal_reset === 1'b1) n_rst++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read strobe; data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic set_count(input logic [15:0] c);
    wr_reg(COUNTER_LOW_ADDR, c[7:0]);
    wr_reg(COUNTER_HIGH_ADDR, c[15:8]);
  endtask

  // Reset values, field mask, unmapped place
  task automatic t_regs();
    for (int i = 0; i < NUM_MODULES; i++) begin
      rd_reg(MODE_BASE + 8'(i), d);
      chk(16'(d), 16'h0000);
    end
    rd_reg(COUNTER_LOW_ADDR, d);
    chk(16'(d), 16'h0000);
    rd_reg(8'h00, d);
    chk(16'(d), 16'h0000);
    wr_reg(MODE_BASE, 8'hff);
    rd_reg(MODE_BASE, d);
    chk(16'(d), 16'h007f);
    wr_reg(MODE_BASE, 8'h00);
  endtask

  // Compare byte writes move the comparator enable
  task automatic t_side_effects();
    for (int i = 0; i < NUM_MODULES; i++) begin
      wr_reg(COMPARE_HIGH_BASE + 8'(i), 8'h00);
      rd_reg(MODE_BASE + 8'(i), d);
      chk(16'(d), 16'h0040);
      wr_reg(COMPARE_LOW_BASE + 8'(i), 8'h00);
      rd_reg(MODE_BASE + 8'(i), d);
      chk(16'(d), 16'h0000);
    end
  endtask

  // Capture on both edges with counter held still
  task automatic t_capture();
    logic [7:0] h;
    wr_reg(MODE_BASE + 8'd1, 8'h31);
    set_count(16'h1234);
    drive[1] <= 1'b0;
    repeat (6) @(posedge clk);
    rd_reg(COMPARE_LOW_BASE + 8'd1, d);
    rd_reg(COMPARE_HIGH_BASE + 8'd1, h);
    chk({h, d}, 16'h1234);
    chk(16'(irq_request), 16'h0001);
    rd_reg(ARRAY_CONTROL_ADDR, d);
    chk(16'(d), 16'h0002);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    chk(16'(irq_request), 16'h0000);
    set_count(16'h5678);
    drive[1] <= 1'b1;
    repeat (6) @(posedge clk);
    rd_reg(COMPARE_LOW_BASE + 8'd1, d);
    rd_reg(COMPARE_HIGH_BASE + 8'd1, h);
    chk({h, d}, 16'h5678);
    rd_reg(ARRAY_CONTROL_ADDR, d);
    chk(16'(d), 16'h0002);
    wr_reg(MODE_BASE + 8'd1, 8'h00);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h00);
  endtask

  // Toggle output on a match
  task automatic t_toggle();
    wr_reg(COMPARE_LOW_BASE + 8'd2, 8'h10);
    wr_reg(COMPARE_HIGH_BASE + 8'd2, 8'h00);
    wr_reg(MODE_BASE + 8'd2, 8'h4c);
    set_count(16'h0000);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h40);
    repeat (40) @(posedge clk);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h00);
    #1 chk(16'(pin_out[2]), 16'h0000);
    chk(16'(pin_oe_n[2]), 16'h0000);
    wr_reg(MODE_BASE + 8'd2, 8'h00);
  endtask

  // Pwm duty from reload byte after a wrap
  task automatic t_pwm();
    wr_reg(COMPARE_HIGH_BASE + 8'd3, 8'h80);
    wr_reg(MODE_BASE + 8'd3, 8'h42);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h40);
    repeat (300) @(posedge clk);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h00);
    wr_reg(COUNTER_LOW_ADDR, 8'h7f);
    repeat (3) @(posedge clk);
    #1 chk(16'(pin_out[3]), 16'h0000);
    wr_reg(COUNTER_LOW_ADDR, 8'h80);
    repeat (3) @(posedge clk);
    #1 chk(16'(pin_out[3]), 16'h0001);
    wr_reg(MODE_BASE + 8'd3, 8'h02);
    wr_reg(COUNTER_LOW_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(16'(pin_oe_n[3]), 16'h0001);
  endtask

  // Guard timer: silent while disabled, reset on match when enabled
  task automatic t_guard();
    int base;
    wr_reg(COMPARE_LOW_BASE + 8'd4, 8'h20);
    wr_reg(COMPARE_HIGH_BASE + 8'd4, 8'h00);
    wr_reg(MODE_BASE + 8'd4, 8'h48);
    set_count(16'h0000);
    base = n_rst;
    wr_reg(ARRAY_CONTROL_ADDR, 8'h40);
    repeat (60) @(posedge clk);
    chk(16'(n_rst - base), 16'h0000);
    rd_reg(ARRAY_CONTROL_ADDR, d);
    chk(16'(d & 8'h10), 16'h0010);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h00);
    set_count(16'h0000);
    wr_reg(ARRAY_MODE_ADDR, 8'h40);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h40);
    repeat (60) @(posedge clk);
    chk(16'(n_rst - base), 16'h0001);
    wr_reg(ARRAY_MODE_ADDR, 8'h00);
    wr_reg(ARRAY_CONTROL_ADDR, 8'h00);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_side_effects();
    t_capture();
    t_toggle();
    t_pwm();
    t_guard();
    print_verdict();
  end
endmodule // counter_array_tb_top
